// [hdl/bfc_top.sv]
// Battery front-end control: filters, channel select, power-on sequence, protection and gate drive.
// Assumes analog comparators and modulators on pins, software bits as plain levels on mclk.
// How it works
// - Coulomb filter gives 16-bit result
// - Coulomb result every 250 ms when enabled
// - Filters step on slow oscillator ticks
// - General converter gives 24-bit result
// - Second synchronous result from coulomb bitstream
// - Period 31.25 ms default, down to 1.95
// - Input range follows selected channel
// - Mux channel, thermistor bias, input short
// - Reset held until regulator good long enough
// - Trim words written after hold time
// - Two-wire link default, single-wire selectable
// - Safety faults switch both gates off
// - Both enables zero turn gates off
// - Slow oscillator failure flagged when too slow
// - Fast clock synthesized, halved, 50 percent
// - Overcurrent threshold, delay from config, tuned
// - Overcurrent passes filtered delay before shutoff
// - Overcurrent latch set until cleared, gone
// - Each cell balance switch own bit
// - Short circuit latches set, held likewise
`timescale 1ns/1ps
`default_nettype none
`include "bfc_cfg.svh"
module bfc_top #(
	parameter int RST_HOLD_CYC = `BFC_RST_HOLD_CYC
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic slow_oscillator,
	input wire logic coulomb_counter_bit,
	input wire logic gp_modulator_bit,
	input wire logic regulator_good,
	input wire logic discharge_overcurrent,
	input wire logic short_in_charge,
	input wire logic short_in_discharge_first,
	input wire logic short_in_discharge_second,
	input wire logic overload_discharge_fault,
	input wire logic overvoltage_fault,
	input wire logic coulomb_conv_enable,
	input wire logic gp_conv_enable,
	input wire logic [2:0] gp_rate_sel,
	input wire logic [3:0] mux_sel,
	input wire logic therm_bias_en,
	input wire logic mux_short_en,
	input wire logic balance_first_cell_en,
	input wire logic balance_second_cell_en,
	input wire logic link_select,
	input wire logic [7:0] discharge_overcurrent_config,
	input wire logic [1:0] protection_tune,
	input wire logic charge_gate_enable,
	input wire logic discharge_gate_enable,
	input wire logic gate_enable_wr,
	input wire logic [4:0] latch_clear,
	input wire logic [15:0] trim_word,
	output logic [15:0] cc_result_q,
	output logic cc_valid_q,
	output logic [23:0] gp_result_q,
	output logic [23:0] gp_cc_result_q,
	output logic gp_valid_q,
	output logic [1:0] gp_range_q,
	output logic [3:0] mux_ch_q,
	output logic therm_bias_q,
	output logic mux_short_q,
	output logic core_reset_q,
	output logic [1:0] trim_idx_q,
	output logic trim_wr_q,
	output logic [1:0] trim_waddr_q,
	output logic [15:0] trim_data_q,
	output logic host_link_mode_q,
	output logic [7:0] fast_mult_q,
	output logic [1:0] fast_div_q,
	output logic [4:0] ocd_thresh_q,
	output logic [4:0] latch_q,
	output logic charge_fet_gate_q,
	output logic discharge_fet_gate_q,
	output logic balance_first_q,
	output logic balance_second_q
);
	logic [`BFC_PIN_N-1:0] pin_raw;
	logic [`BFC_PIN_N-1:0] pin_s1_q;
	logic [`BFC_PIN_N-1:0] pin_s2_q;
	logic slow_d1_q;
	logic slow_tick;
	bfc_pkg::bfc_por_t por_q;
	logic [19:0] hold_cnt_q;
	logic run;
	logic cc_run;
	logic [15:0] cc_win_q;
	logic gp_run;
	logic [2:0] gp_sel_q;
	logic [13:0] gp_win_q;
	logic [13:0] gp_last;
	logic [3:0] gp_sh;
	logic [9:0] ocd_delay;
	logic [9:0] ocd_cnt_q;
	logic ocd_trip;
	logic [8:0] osc_cnt_q;
	logic osc_fail;
	logic [`BFC_LAT_N-1:0] lat_set;
	logic fault_now;
	logic block_q;

	bfc_decim_if #(.W(17)) cc_if ();
	bfc_decim_if #(.W(14)) gp_if ();
	bfc_decim_if #(.W(14)) gx_if ();

	function automatic logic [1:0] bfc_range(input logic [3:0] ch);
		case (bfc_pkg::bfc_mux_ch_t'(ch))
			bfc_pkg::BFC_CH_CELL1, bfc_pkg::BFC_CH_CELL2, bfc_pkg::BFC_CH_PACK: bfc_range = `BFC_RANGE_HIGH;
			bfc_pkg::BFC_CH_GND: bfc_range = `BFC_RANGE_LOW;
			default: bfc_range = `BFC_RANGE_MID;
		endcase
	endfunction : bfc_range

	// Pin synchronisers
	always_comb begin
		pin_raw = '0;
		pin_raw[`BFC_PIN_SLOW] = slow_oscillator;
		pin_raw[`BFC_PIN_CCBIT] = coulomb_counter_bit;
		pin_raw[`BFC_PIN_GPBIT] = gp_modulator_bit;
		pin_raw[`BFC_PIN_REGOK] = regulator_good;
		pin_raw[`BFC_PIN_OCD] = discharge_overcurrent;
		pin_raw[`BFC_PIN_SCC] = short_in_charge;
		pin_raw[`BFC_PIN_SHORT_IN_DISCHARGE_FIRST] = short_in_discharge_first;
		pin_raw[`BFC_PIN_SHORT_IN_DISCHARGE_SECOND] = short_in_discharge_second;
		pin_raw[`BFC_PIN_OLD] = overload_discharge_fault;
		pin_raw[`BFC_PIN_SOV] = overvoltage_fault;
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			slow_d1_q <= 1'h0;
		end else begin
			pin_s1_q <= pin_raw;
			pin_s2_q <= pin_s1_q;
			slow_d1_q <= pin_s2_q[`BFC_PIN_SLOW];
		end
	end
	assign slow_tick = pin_s2_q[`BFC_PIN_SLOW] && !slow_d1_q;

	// Power-on hold and trim load
	always_ff @(posedge mclk) begin
		if (!resetn || !pin_s2_q[`BFC_PIN_REGOK]) begin
			por_q <= bfc_pkg::BFC_POR_HOLD;
			hold_cnt_q <= 20'h00000;
		end else begin
			unique case (por_q)
				bfc_pkg::BFC_POR_HOLD: begin
					if (hold_cnt_q == 20'(RST_HOLD_CYC - 1)) begin
						por_q <= bfc_pkg::BFC_POR_TRIM;
					end else begin
						hold_cnt_q <= hold_cnt_q + 20'h00001;
					end
				end
				bfc_pkg::BFC_POR_TRIM: begin
					if (trim_idx_q == 2'(`BFC_TRIM_WORDS - 1)) begin
						por_q <= bfc_pkg::BFC_POR_RUN;
					end
				end
				bfc_pkg::BFC_POR_RUN: begin
				end
			endcase
		end
	end
	assign run = (por_q == bfc_pkg::BFC_POR_RUN);

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			trim_idx_q <= 2'h0;
			trim_wr_q <= 1'h0;
			trim_waddr_q <= 2'h0;
			trim_data_q <= 16'h0000;
			core_reset_q <= 1'h1;
		end else begin
			trim_wr_q <= (por_q == bfc_pkg::BFC_POR_TRIM);
			trim_waddr_q <= trim_idx_q;
			trim_data_q <= trim_word;
			trim_idx_q <= (por_q == bfc_pkg::BFC_POR_TRIM) ? trim_idx_q + 2'h1 : 2'h0;
			core_reset_q <= !run;
		end
	end

	// Coulomb filter, one window of slow ticks
	assign cc_run = run && coulomb_conv_enable;
	always_ff @(posedge mclk) begin
		if (!resetn || !cc_run) begin
			cc_win_q <= 16'h0000;
		end else if (slow_tick) begin
			cc_win_q <= (cc_win_q == 16'(`BFC_CC_WIN_TICKS - 1)) ? 16'h0000 : cc_win_q + 16'h0001;
		end
	end
	assign cc_if.tick = slow_tick;
	assign cc_if.bit_in = pin_s2_q[`BFC_PIN_CCBIT];
	assign cc_if.dump = (cc_win_q == 16'(`BFC_CC_WIN_TICKS - 1));
	assign cc_if.clr = !cc_run;
	bfc_decim #(.W(17)) u_cc (.mclk(mclk), .resetn(resetn), .f(cc_if.filt));

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			cc_result_q <= 16'h0000;
			cc_valid_q <= 1'h0;
		end else begin
			cc_valid_q <= cc_if.done;
			if (cc_if.done) begin
				cc_result_q <= cc_if.count[16] ? 16'hFFFF : cc_if.count[15:0];
			end
		end
	end

	// General converter filter pair sharing one window
	assign gp_run = run && gp_conv_enable;
	assign gp_last = 14'((`BFC_GP_MIN_TICKS << gp_sel_q) - 1);
	assign gp_sh = 4'(`BFC_GP_SCALE_SH) + 4'(`BFC_GP_MAX_SEL - gp_sel_q);
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			gp_sel_q <= `BFC_GP_DEF_SEL;
		end else if (gp_win_q == 14'h0000) begin
			gp_sel_q <= (gp_rate_sel > `BFC_GP_MAX_SEL) ? `BFC_GP_MAX_SEL : gp_rate_sel;
		end
	end
	always_ff @(posedge mclk) begin
		if (!resetn || !gp_run) begin
			gp_win_q <= 14'h0000;
		end else if (slow_tick) begin
			gp_win_q <= (gp_win_q == gp_last) ? 14'h0000 : gp_win_q + 14'h0001;
		end
	end
	assign gp_if.tick = slow_tick;
	assign gp_if.bit_in = pin_s2_q[`BFC_PIN_GPBIT];
	assign gp_if.dump = (gp_win_q == gp_last);
	assign gp_if.clr = !gp_run;
	assign gx_if.tick = slow_tick;
	assign gx_if.bit_in = pin_s2_q[`BFC_PIN_CCBIT];
	assign gx_if.dump = (gp_win_q == gp_last);
	assign gx_if.clr = !gp_run;
	bfc_decim #(.W(14)) u_gp (.mclk(mclk), .resetn(resetn), .f(gp_if.filt));
	bfc_decim #(.W(14)) u_gx (.mclk(mclk), .resetn(resetn), .f(gx_if.filt));

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			gp_result_q <= 24'h000000;
			gp_cc_result_q <= 24'h000000;
			gp_valid_q <= 1'h0;
		end else begin
			gp_valid_q <= gp_if.done;
			if (gp_if.done) begin
				gp_result_q <= 24'(gp_if.count) << gp_sh;
				gp_cc_result_q <= 24'(gx_if.count) << gp_sh;
			end
		end
	end

	// Channel select, range, link mode, clocks, balancing
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			mux_ch_q <= 4'(bfc_pkg::BFC_CH_GND);
			therm_bias_q <= 1'h0;
			mux_short_q <= 1'h0;
			gp_range_q <= `BFC_RANGE_LOW;
			host_link_mode_q <= 1'h0;
			fast_mult_q <= `BFC_FAST_MULT;
			fast_div_q <= `BFC_FAST_DIV;
			balance_first_q <= 1'h0;
			balance_second_q <= 1'h0;
		end else begin
			mux_ch_q <= (mux_sel > 4'(bfc_pkg::BFC_CH_GND)) ? 4'(bfc_pkg::BFC_CH_GND) : mux_sel;
			therm_bias_q <= therm_bias_en;
			mux_short_q <= mux_short_en;
			gp_range_q <= bfc_range(mux_ch_q);
			host_link_mode_q <= link_select;
			fast_mult_q <= `BFC_FAST_MULT;
			fast_div_q <= `BFC_FAST_DIV;
			balance_first_q <= run && balance_first_cell_en;
			balance_second_q <= run && balance_second_cell_en;
		end
	end

	// Discharge overcurrent filtered delay
	assign ocd_delay = (10'(discharge_overcurrent_config[7:4]) + 10'h001)
		<< (`BFC_OCD_STEP_SH + 32'(protection_tune[1]));
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ocd_cnt_q <= 10'h000;
			ocd_thresh_q <= 5'h00;
		end else begin
			ocd_thresh_q <= protection_tune[0] ? {discharge_overcurrent_config[3:0], 1'h0}
				: {1'h0, discharge_overcurrent_config[3:0]};
			if (slow_tick) begin
				if (pin_s2_q[`BFC_PIN_OCD]) begin
					ocd_cnt_q <= (ocd_cnt_q >= ocd_delay) ? ocd_delay : ocd_cnt_q + 10'h001;
				end else if (ocd_cnt_q != 10'h000) begin
					ocd_cnt_q <= ocd_cnt_q - 10'h001;
				end
			end
		end
	end
	assign ocd_trip = pin_s2_q[`BFC_PIN_OCD] && (ocd_cnt_q >= ocd_delay);

	// Slow oscillator monitor
	always_ff @(posedge mclk) begin
		if (!resetn || slow_tick) begin
			osc_cnt_q <= 9'h000;
		end else if (osc_cnt_q != 9'(`BFC_OSC_FAIL_CYC)) begin
			osc_cnt_q <= osc_cnt_q + 9'h001;
		end
	end
	assign osc_fail = (osc_cnt_q == 9'(`BFC_OSC_FAIL_CYC));

	// Latched status, set wins over clear
	always_comb begin
		lat_set = '0;
		lat_set[`BFC_LAT_OCD] = ocd_trip;
		lat_set[`BFC_LAT_SCC] = pin_s2_q[`BFC_PIN_SCC];
		lat_set[`BFC_LAT_SHORT_IN_DISCHARGE_FIRST] = pin_s2_q[`BFC_PIN_SHORT_IN_DISCHARGE_FIRST];
		lat_set[`BFC_LAT_SHORT_IN_DISCHARGE_SECOND] = pin_s2_q[`BFC_PIN_SHORT_IN_DISCHARGE_SECOND];
		lat_set[`BFC_LAT_OSC] = osc_fail;
	end
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			latch_q <= 5'h00;
		end else begin
			latch_q <= (latch_q & ~latch_clear) | lat_set;
		end
	end

	// Gate drive
	assign fault_now = ocd_trip || pin_s2_q[`BFC_PIN_SCC] || pin_s2_q[`BFC_PIN_SHORT_IN_DISCHARGE_FIRST]
		|| pin_s2_q[`BFC_PIN_SHORT_IN_DISCHARGE_SECOND] || pin_s2_q[`BFC_PIN_OLD] || pin_s2_q[`BFC_PIN_SOV];
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			block_q <= 1'h0;
		end else if (fault_now) begin
			block_q <= 1'h1;
		end else if (gate_enable_wr && (latch_q[`BFC_LAT_SHORT_IN_DISCHARGE_SECOND:`BFC_LAT_OCD] == 4'h0)) begin
			block_q <= 1'h0;
		end
	end
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			charge_fet_gate_q <= 1'h0;
			discharge_fet_gate_q <= 1'h0;
		end else begin
			charge_fet_gate_q <= run && charge_gate_enable && !block_q && !fault_now;
			discharge_fet_gate_q <= run && discharge_gate_enable && !block_q && !fault_now;
		end
	end

	cc_sat_a: assert property (@(posedge mclk) disable iff (!resetn)
		cc_if.done |=> cc_result_q == ($past(cc_if.count[16]) ? 16'hFFFF : $past(cc_if.count[15:0])))
		else $error("coulomb result not saturated count");
	cc_period_a: assert property (@(posedge mclk) disable iff (!resetn)
		cc_valid_q |-> cc_win_q == 16'h0000 && $past(coulomb_conv_enable, 2)) else $error("coulomb result off window");
	filt_tick_a: assert property (@(posedge mclk) disable iff (!resetn)
		gp_if.done |-> $past(slow_tick)) else $error("filter stepped without slow tick");
	gp_scale_a: assert property (@(posedge mclk) disable iff (!resetn)
		gp_valid_q |-> gp_result_q[`BFC_GP_SCALE_SH-1:0] == 10'h000) else $error("general result badly scaled");
	gp_pair_a: assert property (@(posedge mclk) disable iff (!resetn)
		gp_if.done |-> gx_if.done) else $error("paired results not synchronous");
	gp_sel_a: assert property (@(posedge mclk) disable iff (!resetn)
		gp_sel_q <= `BFC_GP_MAX_SEL) else $error("conversion period beyond default");
	gp_range_a: assert property (@(posedge mclk) disable iff (!resetn)
		$past(mux_ch_q) == 4'(bfc_pkg::BFC_CH_GND) |-> gp_range_q == `BFC_RANGE_LOW) else $error("range not from channel");
	por_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
		!pin_s2_q[`BFC_PIN_REGOK] |=> ##1 core_reset_q) else $error("reset released with regulator low");
	trim_first_a: assert property (@(posedge mclk) disable iff (!resetn)
		$rose(run) |-> $past(por_q) == bfc_pkg::BFC_POR_TRIM) else $error("run entered without trim");
	fet_fault_a: assert property (@(posedge mclk) disable iff (!resetn)
		fault_now |=> !charge_fet_gate_q && !discharge_fet_gate_q) else $error("gate on during fault");
	fet_manual_a: assert property (@(posedge mclk) disable iff (!resetn)
		!charge_gate_enable && !discharge_gate_enable |=> !charge_fet_gate_q && !discharge_fet_gate_q)
		else $error("gates on with enables low");
	osc_flag_a: assert property (@(posedge mclk) disable iff (!resetn)
		osc_fail |=> latch_q[`BFC_LAT_OSC]) else $error("oscillator failure not flagged");
	ocd_latch_a: assert property (@(posedge mclk) disable iff (!resetn)
		ocd_trip |=> latch_q[`BFC_LAT_OCD] && !charge_fet_gate_q) else $error("overcurrent not latched");
	lat_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
		latch_clear[`BFC_LAT_SCC] && !lat_set[`BFC_LAT_SCC] |=> !latch_q[`BFC_LAT_SCC]) else $error("latch not cleared");
	gate_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
		block_q && !gate_enable_wr |=> block_q) else $error("gate block dropped by itself");
endmodule : bfc_top
`default_nettype wire

// [hdl/bfc_cfg.svh]
// Named constants of the battery front-end control block.
// Assumes mclk at 40 MHz and a slow oscillator pin near 262.144 kHz.
`ifndef BFC_CFG_SVH
`define BFC_CFG_SVH

`define BFC_MCLK_HZ 40000000
`define BFC_SLOW_HZ 262144
`define BFC_CC_PERIOD_MS 250
`define BFC_CC_WIN_TICKS (`BFC_CC_PERIOD_MS * `BFC_SLOW_HZ / 1000)
`define BFC_GP_DEF_PERIOD_US 31250
`define BFC_GP_MIN_PERIOD_US 1950
`define BFC_GP_MIN_TICKS ((`BFC_GP_MIN_PERIOD_US * `BFC_SLOW_HZ + 999999) / 1000000)
`define BFC_GP_DEF_SEL 3'h4
`define BFC_GP_MAX_SEL 3'h4
`define BFC_GP_SCALE_SH 10
`define BFC_OSC_FAIL_CYC (2 * `BFC_MCLK_HZ / `BFC_SLOW_HZ)
`define BFC_RST_HOLD_US 1000
`define BFC_RST_HOLD_CYC (`BFC_RST_HOLD_US * (`BFC_MCLK_HZ / 1000000))
`define BFC_TRIM_WORDS 4
`define BFC_OCD_STEP_SH 3
`define BFC_FAST_MULT 8'h40
`define BFC_FAST_DIV 2'h2
`define BFC_PIN_SLOW 0
`define BFC_PIN_CCBIT 1
`define BFC_PIN_GPBIT 2
`define BFC_PIN_REGOK 3
`define BFC_PIN_OCD 4
`define BFC_PIN_SCC 5
`define BFC_PIN_SHORT_IN_DISCHARGE_FIRST 6
`define BFC_PIN_SHORT_IN_DISCHARGE_SECOND 7
`define BFC_PIN_OLD 8
`define BFC_PIN_SOV 9
`define BFC_PIN_N 10
`define BFC_LAT_OCD 0
`define BFC_LAT_SCC 1
`define BFC_LAT_SHORT_IN_DISCHARGE_FIRST 2
`define BFC_LAT_SHORT_IN_DISCHARGE_SECOND 3
`define BFC_LAT_OSC 4
`define BFC_LAT_N 5
`define BFC_RANGE_LOW 2'h0
`define BFC_RANGE_MID 2'h1
`define BFC_RANGE_HIGH 2'h2

`endif

// [hdl/bfc_pkg.sv]
// Types of the battery front-end control block.
// Assumes nothing beyond the constants header.
`default_nettype none
package bfc_pkg;
	typedef enum logic [3:0] {
		BFC_CH_CELL1, BFC_CH_CELL2, BFC_CH_THERM, BFC_CH_TEMP, BFC_CH_REF1,
		BFC_CH_REF2, BFC_CH_REG, BFC_CH_PACK, BFC_CH_GND
	} bfc_mux_ch_t;
	typedef enum logic [1:0] {BFC_POR_HOLD, BFC_POR_TRIM, BFC_POR_RUN} bfc_por_t;
endpackage : bfc_pkg
`default_nettype wire

// [hdl/bfc_decim_if.sv]
// Carrier between the top and one decimation filter.
// Assumes all signals on mclk.
`timescale 1ns/1ps
`default_nettype none
interface bfc_decim_if #(parameter int W = 16);
	logic tick;
	logic bit_in;
	logic dump;
	logic clr;
	logic [W-1:0] count;
	logic done;
	modport filt (input tick, input bit_in, input dump, input clr, output count, output done);
	modport ctrl (output tick, output bit_in, output dump, output clr, input count, input done);
endinterface : bfc_decim_if
`default_nettype wire

// [hdl/bfc_decim.sv]
// Integrate-and-dump decimation filter on slow oscillator ticks.
// Assumes tick, bit and dump come from mclk logic already synchronised.
`timescale 1ns/1ps
`default_nettype none
module bfc_decim #(parameter int W = 16) (
	input wire logic mclk,
	input wire logic resetn,
	bfc_decim_if.filt f
);
	logic [W-1:0] acc_q;

	always_ff @(posedge mclk) begin
		if (!resetn || f.clr) begin
			acc_q <= '0;
			f.count <= '0;
			f.done <= 1'h0;
		end else begin
			f.done <= 1'h0;
			if (f.tick) begin
				if (f.dump) begin
					f.count <= acc_q + W'(f.bit_in);
					acc_q <= '0;
					f.done <= 1'h1;
				end else begin
					acc_q <= acc_q + W'(f.bit_in);
				end
			end
		end
	end
endmodule : bfc_decim
`default_nettype wire

// [verif/bfc_afe_model.sv]
// Far-side model of the front end: slow oscillator source and stored trim words.
// Assumes mclk from the bench; the oscillator half period is counted in mclk cycles.
`timescale 1ns/1ps
`default_nettype none
module bfc_afe_model #(
	parameter int HALF = 2,
	parameter logic [15:0] TRIM_BASE = 16'hC3A0
) (
	input wire logic mclk,
	input wire logic stop,
	input wire logic [1:0] trim_idx,
	output logic slow_oscillator,
	output logic [15:0] trim_word
);
	int cnt = 0;
	initial slow_oscillator = 1'b0;
	// Oscillator halts low while stopped
	always @(posedge mclk) begin
		if (stop) begin
			slow_oscillator <= 1'b0;
			cnt <= 0;
		end else if (cnt == HALF - 1) begin
			slow_oscillator <= ~slow_oscillator;
			cnt <= 0;
		end else begin
			cnt <= cnt + 1;
		end
	end
	// Trim store answers in the same cycle
	assign trim_word = TRIM_BASE | {14'h0000, trim_idx};
endmodule : bfc_afe_model
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench of the battery front-end control block.
// Assumes the front-end model supplies the slow oscillator and the trim store.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int HOLD = 20;
	localparam int TPER = 4;
	localparam logic [15:0] TBASE = 16'hC3A0;
	logic mclk, slow_oscillator;
	logic resetn = 1'b0, coulomb_counter_bit = 1'b0, gp_modulator_bit = 1'b0, regulator_good = 1'b0;
	logic discharge_overcurrent = 1'b0, coulomb_conv_enable = 1'b0, gp_conv_enable = 1'b0;
	logic therm_bias_en = 1'b0, mux_short_en = 1'b0, link_select = 1'b0, osc_stop = 1'b0;
	logic balance_first_cell_en = 1'b0, balance_second_cell_en = 1'b0, gate_enable_wr = 1'b0;
	logic charge_gate_enable = 1'b0, discharge_gate_enable = 1'b0;
	logic [4:0] fv = 5'h00, latch_clear = 5'h00;
	logic [2:0] gp_rate_sel = 3'h0;
	logic [3:0] mux_sel = 4'h0;
	logic [7:0] discharge_overcurrent_config = 8'h00;
	logic [1:0] protection_tune = 2'h0;
	logic [4:0] ocd_thresh_q, latch_q;
	logic [3:0] mux_ch_q;
	logic [7:0] fast_mult_q;
	logic [1:0] gp_range_q, trim_idx_q, trim_waddr_q, fast_div_q;
	logic [15:0] trim_word, cc_result_q, trim_data_q;
	logic [23:0] gp_result_q, gp_cc_result_q;
	logic cc_valid_q, gp_valid_q, therm_bias_q, mux_short_q, core_reset_q, trim_wr_q, host_link_mode_q;
	logic charge_fet_gate_q, discharge_fet_gate_q, balance_first_q, balance_second_q;
	wire logic short_in_charge = fv[0];
	wire logic short_in_discharge_first = fv[1];
	wire logic short_in_discharge_second = fv[2];
	wire logic overload_discharge_fault = fv[3];
	wire logic overvoltage_fault = fv[4];
	int fail_count = 0;
	int num_checks = 0;
	int cycles = 0;
	logic [31:0] rs = 32'h00010151;
	logic cc_seen = 1'b0;
	logic [17:0] trim_q[$];

	bfc_top #(.RST_HOLD_CYC(HOLD)) bfc_top_inst (
		.mclk, .resetn, .slow_oscillator, .coulomb_counter_bit, .gp_modulator_bit, .regulator_good,
		.discharge_overcurrent, .short_in_charge, .short_in_discharge_first, .short_in_discharge_second,
		.overload_discharge_fault, .overvoltage_fault, .coulomb_conv_enable, .gp_conv_enable,
		.gp_rate_sel, .mux_sel, .therm_bias_en, .mux_short_en, .balance_first_cell_en,
		.balance_second_cell_en, .link_select, .discharge_overcurrent_config, .protection_tune,
		.charge_gate_enable, .discharge_gate_enable, .gate_enable_wr, .latch_clear, .trim_word,
		.cc_result_q, .cc_valid_q, .gp_result_q, .gp_cc_result_q, .gp_valid_q, .gp_range_q, .mux_ch_q,
		.therm_bias_q, .mux_short_q, .core_reset_q, .trim_idx_q, .trim_wr_q, .trim_waddr_q, .trim_data_q,
		.host_link_mode_q, .fast_mult_q, .fast_div_q, .ocd_thresh_q, .latch_q, .charge_fet_gate_q,
		.discharge_fet_gate_q, .balance_first_q, .balance_second_q
	);
	bfc_afe_model bfc_afe_model_inst (
		.mclk, .stop(osc_stop), .trim_idx(trim_idx_q), .slow_oscillator, .trim_word
	);

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	function automatic logic [31:0] xs();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction : xs

	function automatic logic [1:0] range_of(input int ch);
		if (ch == 8) return 2'h0;
		if (ch < 2 || ch == 7) return 2'h2;
		return 2'h1;
	endfunction : range_of

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic end_of_test();
		if (fail_count == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_of_test

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : cyc

	task automatic set_gates(input logic c, input logic d);
		@(posedge mclk);
		charge_gate_enable <= c;
		discharge_gate_enable <= d;
		gate_enable_wr <= 1'b1;
		@(posedge mclk);
		gate_enable_wr <= 1'b0;
		cyc(3);
	endtask : set_gates

	task automatic clr(input logic [4:0] mask);
		@(posedge mclk);
		latch_clear <= mask;
		@(posedge mclk);
		latch_clear <= 5'h00;
		cyc(2);
	endtask : clr

	task automatic wait_gp(output int n);
		n = 0;
		do begin
			cyc(1);
			n++;
		end while (gp_valid_q !== 1'b1 && n < 40000);
		chk(gp_valid_q, 1);
	endtask : wait_gp

	always @(posedge mclk) begin
		cycles++;
		if (cycles > 40000) begin
			fail_count++;
			end_of_test();
		end
	end
	always @(posedge mclk) if (trim_wr_q === 1'b1) trim_q.push_back({trim_waddr_q, trim_data_q});
	always @(posedge mclk) if (cc_valid_q === 1'b1) cc_seen <= 1'b1;

	initial begin
		int n;
		int ch;
		logic [31:0] r;
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		cyc(0);
		chk(mux_ch_q, 4'h8);
		chk({fast_mult_q, fast_div_q}, {8'h40, 2'h2});
		chk(host_link_mode_q, 0);
		cyc(30);
		chk(core_reset_q, 1);
		chk(trim_q.size(), 0);
		@(posedge mclk);
		regulator_good <= 1'b1;
		n = 0;
		do begin
			cyc(1);
			n++;
		end while (core_reset_q !== 1'b0 && n < 200);
		chk(n > HOLD + 2 && n < HOLD + 12, 1);
		chk(trim_q.size(), 4);
		for (int i = 0; i < 4; i++) chk(trim_q[i], {i[1:0], TBASE | i[15:0]});
		for (int k = 0; k < 12; k++) begin
			r = xs();
			@(posedge mclk);
			mux_sel <= r[3:0];
			therm_bias_en <= r[4];
			mux_short_en <= r[5];
			balance_first_cell_en <= r[6];
			balance_second_cell_en <= r[7];
			link_select <= r[8];
			discharge_overcurrent_config <= r[23:16];
			protection_tune <= r[25:24];
			cyc(3);
			ch = (r[3:0] > 4'h8) ? 8 : int'(r[3:0]);
			chk(mux_ch_q, ch);
			chk(gp_range_q, range_of(ch));
			chk({therm_bias_q, mux_short_q}, {r[4], r[5]});
			chk({balance_second_q, balance_first_q}, r[7:6]);
			chk(host_link_mode_q, r[8]);
			chk(ocd_thresh_q, {1'b0, r[19:16]} << r[24]);
		end
		@(posedge mclk);
		discharge_overcurrent_config <= 8'h00;
		for (int g = 0; g < 4; g++) begin
			set_gates(g[1], g[0]);
			chk({charge_fet_gate_q, discharge_fet_gate_q}, g[1:0]);
		end
		for (int i = 0; i < 5; i++) begin
			@(posedge mclk);
			fv[i] <= 1'b1;
			cyc(4);
			chk({charge_fet_gate_q, discharge_fet_gate_q}, 0);
			if (i < 3) chk(latch_q[i+1], 1);
			clr(5'h1F);
			if (i < 3) chk(latch_q[i+1], 1);
			set_gates(1'b1, 1'b1);
			chk({charge_fet_gate_q, discharge_fet_gate_q}, 0);
			@(posedge mclk);
			fv[i] <= 1'b0;
			cyc(4);
			if (i < 3) chk(latch_q[i+1], 1);
			chk({charge_fet_gate_q, discharge_fet_gate_q}, 0);
			clr(5'h1F);
			chk(latch_q, 0);
			set_gates(1'b1, 1'b1);
			chk({charge_fet_gate_q, discharge_fet_gate_q}, 2'h3);
		end
		for (int t = 0; t < 2; t++) begin
			@(posedge mclk);
			protection_tune <= {t[0], 1'b0};
			discharge_overcurrent <= 1'b1;
			n = 0;
			do begin
				cyc(1);
				n++;
			end while (discharge_fet_gate_q !== 1'b0 && n < 300);
			chk(n >= (8 << t) * TPER - 4 && n <= (8 << t) * TPER + 12, 1);
			chk(latch_q[0], 1);
			@(posedge mclk);
			discharge_overcurrent <= 1'b0;
			cyc(300);
			chk(latch_q[0], 1);
			clr(5'h01);
			chk(latch_q[0], 0);
			set_gates(1'b1, 1'b1);
		end
		@(posedge mclk);
		osc_stop <= 1'b1;
		cyc(250);
		chk(latch_q[4], 0);
		cyc(150);
		chk(latch_q[4], 1);
		@(posedge mclk);
		osc_stop <= 1'b0;
		cyc(20);
		clr(5'h10);
		chk(latch_q[4], 0);
		@(posedge mclk);
		gp_conv_enable <= 1'b1;
		coulomb_conv_enable <= 1'b1;
		for (int s = 0; s < 2; s++) begin
			@(posedge mclk);
			gp_rate_sel <= s[2:0];
			gp_modulator_bit <= ~s[0];
			coulomb_counter_bit <= s[0];
			wait_gp(n);
			wait_gp(n);
			wait_gp(n);
			chk(n, (512 << s) * TPER);
			chk(gp_result_q, s[0] ? 24'h000000 : 24'h800000);
			chk(gp_cc_result_q, s[0] ? 24'h800000 : 24'h000000);
		end
		chk(cc_seen, 0);
		chk(cc_result_q, 16'h0000);
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
